/* rtl/serial_zero_pkg.sv */
// Package: shared types and constants for serial port zero
package serial_zero_pkg;

  localparam int DATA_WIDTH = 8;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [3:0] CNT_WRAP = 4'h9;
  localparam logic [3:0] CNT_RESTART = 4'h1;
  localparam logic [3:0] CNT_ACK_DRIVE = 4'h8;
  localparam logic [3:0] CNT_ACK_FETCH = 4'h9;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam int CLOCK_HZ = 25000000;
  localparam int SHIFT_HALF_NS = 5000;
  localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS * (CLOCK_HZ / 1000000))
    / 1000;
  localparam int MIN_HALF_CYC = 4;

  typedef enum logic [1:0]
  {
    MODE_I2C = 2'h0,
    MODE_TWO_WIRE = 2'h1,
    MODE_THREE_WIRE = 2'h2
  } comm_mode_e;

  // Software control flags
  typedef struct packed {
    comm_mode_e mode;
    logic master_role_select;
    logic transmit_direction_select;
    logic data_line_port_direction;
    logic clock_line_port_direction;
    logic three_wire_clock_port_direction;
    logic serial_out_port_direction;
    logic serial_in_port_direction;
  } ctrl_s;

  // General-purpose output latches of the shared pins
  typedef struct packed {
    logic data_line;
    logic clock_line;
    logic three_wire_clock;
    logic serial_out;
    logic serial_in;
  } latch_s;

  // One two-way pin: output level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_s;

endpackage : serial_zero_pkg

/* rtl/shift_clock_gen.sv */
// Internal shift clock generator for master operation
`timescale 1ns/100ps
module shift_clock_gen #(
  parameter int HALF_CYC = serial_zero_pkg::SHIFT_HALF_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  output logic sclk_out
);

  localparam int CW = $clog2(HALF_CYC + 1);

  logic [CW-1:0] div_reg;
  logic [CW-1:0] div_next;
  logic sclk_reg;
  logic sclk_next;

  initial
  begin
    if (HALF_CYC < 1)
    begin
      $error("HALF_CYC must be at least one");
    end
  end

  always_comb
  begin
    div_next = div_reg;
    sclk_next = sclk_reg;
    if (!run_in)
    begin
      div_next = '0;
      sclk_next = 1'b1;
    end
    else if (div_reg == CW'(HALF_CYC - 1))
    begin
      div_next = '0;
      sclk_next = ~sclk_reg;
    end
    else
    begin
      div_next = div_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      div_reg <= '0;
      sclk_reg <= 1'b1;
    end
    else
    begin
      div_reg <= div_next;
      sclk_reg <= sclk_next;
    end
  end

  assign sclk_out = sclk_reg;

endmodule : shift_clock_gen

/* rtl/multimode_serial_port_zero.sv */
// Serial interface channel zero: I2C, two-wire and three-wire modes
`timescale 1ns/100ps
module multimode_serial_port_zero #(
  parameter int HALF_CYC = serial_zero_pkg::SHIFT_HALF_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire serial_zero_pkg::ctrl_s ctrl_in,
  input wire serial_zero_pkg::latch_s latch_in,
  input wire logic clock_stop_in,
  input wire logic ce_reset_in,
  input wire logic halt_in,
  input wire logic wait_release_in,
  input wire logic wait_write_in,
  input wire logic wait_set_in,
  input wire logic shift_load_in,
  input wire logic [7:0] shift_data_in,
  input wire logic data_line_in,
  input wire logic clock_line_in,
  input wire logic three_wire_clock_pin_in,
  input wire logic three_wire_data_in_pin_in,
  output serial_zero_pkg::pin_drive_s data_line_out,
  output serial_zero_pkg::pin_drive_s clock_line_out,
  output serial_zero_pkg::pin_drive_s three_wire_clock_pin_out,
  output serial_zero_pkg::pin_drive_s three_wire_data_out_pin_out,
  output serial_zero_pkg::pin_drive_s three_wire_data_in_pin_out,
  output logic [7:0] serial_shift_register_out,
  output logic [3:0] clock_count_out,
  output logic released_out,
  output logic ack_seen_out
);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } port_state_e;

  port_state_e state_reg;
  port_state_e state_next;
  logic [1:0] sync_data_reg;
  logic [2:0] sync_clk_reg;
  logic [1:0] sync_data_next;
  logic [2:0] sync_clk_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic out_bit_reg;
  logic out_bit_next;
  logic ack_reg;
  logic ack_next;
  serial_zero_pkg::comm_mode_e mode_reg;
  logic int_sclk;
  logic run_clk;
  logic clk_rise;
  logic clk_fall;
  logic is_i2c;
  logic is_three;
  logic master;
  logic tx;
  logic rx_ack_drive;

  initial
  begin
    if (HALF_CYC < serial_zero_pkg::MIN_HALF_CYC)
    begin
      $error("HALF_CYC too short for the pin sampling lag");
    end
  end

  assign is_i2c = ctrl_in.mode == serial_zero_pkg::MODE_I2C;
  assign is_three = ctrl_in.mode == serial_zero_pkg::MODE_THREE_WIRE;
  assign master = ctrl_in.master_role_select;
  assign tx = ctrl_in.transmit_direction_select;
  assign run_clk = master && state_reg == ST_RUN && !halt_in;

  shift_clock_gen #(
    .HALF_CYC(HALF_CYC)
  ) u_clk_gen (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .run_in(run_clk),
    .sclk_out(int_sclk)
  );

  // Pin sampling through two flops, third stage for edge finding
  always_comb
  begin
    sync_clk_next = {sync_clk_reg[1:0],
      is_three ? three_wire_clock_pin_in : clock_line_in};
    sync_data_next = {sync_data_reg[0],
      is_three ? three_wire_data_in_pin_in : data_line_in};
  end

  assign clk_rise = sync_clk_reg[1] && !sync_clk_reg[2];
  assign clk_fall = !sync_clk_reg[1] && sync_clk_reg[2];
  assign rx_ack_drive = is_i2c && !tx && count_reg == serial_zero_pkg::
    CNT_ACK_DRIVE;

  // Wait and run control
  always_comb
  begin
    state_next = state_reg;
    if (clock_stop_in || ce_reset_in)
    begin
      state_next = ST_IDLE;
    end
    else if (wait_set_in)
    begin
      state_next = ST_WAIT;
    end
    else if (wait_release_in)
    begin
      state_next = ST_RUN;
    end
    else if (state_reg == ST_IDLE && wait_write_in)
    begin
      state_next = ST_WAIT;
    end
  end

  // Clock counter, shift register and serial output
  always_comb
  begin
    count_next = count_reg;
    shift_next = shift_reg;
    out_bit_next = out_bit_reg;
    ack_next = ack_reg;
    if (clock_stop_in || ce_reset_in || wait_write_in || wait_release_in
      || (is_i2c && mode_reg != serial_zero_pkg::MODE_I2C))
    begin
      count_next = serial_zero_pkg::CNT_RESET;
    end
    else if (clk_rise && state_reg != ST_IDLE)
    begin
      if (count_reg == serial_zero_pkg::CNT_WRAP)
      begin
        count_next = serial_zero_pkg::CNT_RESTART;
      end
      else
      begin
        count_next = count_reg + 4'h1;
      end
    end
    if (clk_rise && state_reg == ST_RUN && !clock_stop_in)
    begin
      shift_next = {shift_reg[6:0], sync_data_reg[1]};
      if (is_i2c && tx && count_reg == serial_zero_pkg::CNT_ACK_DRIVE)
      begin
        ack_next = !sync_data_reg[1];
      end
    end
    if (tx && ((clk_fall && state_reg == ST_RUN)
      || (wait_release_in && state_reg == ST_WAIT && is_i2c)))
    begin
      out_bit_next = shift_reg[7] || (is_i2c
        && count_reg == serial_zero_pkg::CNT_ACK_DRIVE);
    end
    if (shift_load_in)
    begin
      shift_next = shift_data_in;
      if (state_reg == ST_RUN && !sync_clk_reg[1])
      begin
        out_bit_next = shift_data_in[7];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= ST_IDLE;
      sync_clk_reg <= '1;
      sync_data_reg <= '0;
      count_reg <= serial_zero_pkg::CNT_RESET;
      shift_reg <= serial_zero_pkg::SHIFT_RESET;
      out_bit_reg <= 1'b1;
      ack_reg <= 1'b0;
      mode_reg <= serial_zero_pkg::MODE_I2C;
    end
    else
    begin
      state_reg <= state_next;
      sync_clk_reg <= sync_clk_next;
      sync_data_reg <= sync_data_next;
      count_reg <= count_next;
      shift_reg <= shift_next;
      out_bit_reg <= out_bit_next;
      ack_reg <= ack_next;
      mode_reg <= ctrl_in.mode;
    end
  end

  // Pin drive per mode, role, direction and wait state
  always_comb
  begin
    data_line_out = '0;
    clock_line_out = '0;
    three_wire_clock_pin_out = '0;
    three_wire_data_out_pin_out = '0;
    three_wire_data_in_pin_out = '0;
    if (state_reg != ST_IDLE)
    begin
      if (!is_three)
      begin
        if (tx)
        begin
          data_line_out = '{level: out_bit_reg, oe: !out_bit_reg};
        end
        else if (rx_ack_drive && state_reg == ST_RUN && !sync_clk_reg[1])
        begin
          data_line_out = '{level: 1'b0, oe: 1'b1};
        end
        else
        begin
          data_line_out = '{level: latch_in.data_line,
            oe: ctrl_in.data_line_port_direction};
        end
        if (state_reg == ST_WAIT)
        begin
          if (is_i2c)
          begin
            clock_line_out = '{level: 1'b0, oe: 1'b1};
          end
          else
          begin
            clock_line_out = '0;
          end
        end
        else if (master)
        begin
          clock_line_out = '{level: int_sclk, oe: !int_sclk};
        end
        else
        begin
          clock_line_out = '0;
        end
      end
      else
      begin
        if (master)
        begin
          three_wire_clock_pin_out = '{level: int_sclk, oe: 1'b1};
        end
        else if (state_reg == ST_WAIT
          && ctrl_in.three_wire_clock_port_direction)
        begin
          three_wire_clock_pin_out = '{level: latch_in.three_wire_clock,
            oe: 1'b1};
        end
        if (tx)
        begin
          three_wire_data_out_pin_out = '{level: out_bit_reg, oe: 1'b1};
        end
        else
        begin
          three_wire_data_out_pin_out = '{level: latch_in.serial_out,
            oe: ctrl_in.serial_out_port_direction};
        end
      end
    end
  end

  assign serial_shift_register_out = shift_reg;
  assign clock_count_out = count_reg;
  assign released_out = state_reg == ST_RUN;
  assign ack_seen_out = ack_reg;

  AST_WRAP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    count_reg == serial_zero_pkg::CNT_WRAP && clk_rise && !wait_write_in
    && !wait_release_in && !clock_stop_in && !ce_reset_in && state_reg
    != ST_IDLE && !(is_i2c && mode_reg != serial_zero_pkg::MODE_I2C)
    |=> count_reg == serial_zero_pkg::CNT_RESTART)
    else $error("counter did not wrap to one");
  AST_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wait_write_in || clock_stop_in
    |=> count_reg == serial_zero_pkg::CNT_RESET)
    else $error("counter not cleared");
  AST_IDLE_PINS: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    clock_stop_in |=> !data_line_out.oe && !clock_line_out.oe
    && !three_wire_clock_pin_out.oe && !three_wire_data_out_pin_out.oe)
    else $error("pins driven after clock stop");
  AST_SHIFT_KEEP: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    clock_stop_in && !shift_load_in |=> $stable(shift_reg))
    else $error("shift register changed on clock stop");
  AST_I2C_WAIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == ST_WAIT && is_i2c |-> clock_line_out.oe
    && !clock_line_out.level)
    else $error("clock not held low in wait");
  AST_TWO_WAIT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == ST_WAIT && ctrl_in.mode == serial_zero_pkg::MODE_TWO_WIRE
    |-> !clock_line_out.oe)
    else $error("clock driven in two-wire wait");
  AST_SLAVE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg == ST_RUN && !master && !is_three |-> !clock_line_out.oe)
    else $error("slave drove clock");
  AST_SHIFT_IN: assert property (@(posedge clk_in)
    disable iff (!rst_b_in)
    clk_rise && state_reg == ST_RUN && !shift_load_in && !clock_stop_in
    |=> shift_reg == {$past(shift_reg[6:0]), $past(sync_data_reg[1])})
    else $error("input bit not shifted in");
  AST_TX_OUT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    clk_fall && state_reg == ST_RUN && tx && !shift_load_in
    && !(is_i2c && count_reg == serial_zero_pkg::CNT_ACK_DRIVE)
    |=> out_bit_reg == $past(shift_reg[7]))
    else $error("MSB not sent on fall");
  AST_HALT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    halt_in |=> int_sclk)
    else $error("internal clock ran in halt");

endmodule : multimode_serial_port_zero

/* testbench/serial_peer.sv */
// External serial peer: clock and data source, data sink
`timescale 1ns/100ps
module serial_peer (
  input wire logic sclk_in,
  input wire logic data_in,
  output logic clk_out,
  output logic data_out,
  output logic [7:0] rx_out
);
  initial
  begin
    clk_out = 1'b1;
    data_out = 1'b1;
    rx_out = 8'h00;
  end

  // Sample the line on each rise of the wire clock
  always @(posedge sclk_in)
  begin
    rx_out <= {rx_out[6:0], data_in};
  end

  // Frame of n clocks at 320 ns, MSB first; ack driven from 9th fall
  task automatic frame(input logic [7:0] tx, input int n, input logic ack);
    int i;
    begin
      for (i = 0; i < n; i++)
      begin
        clk_out = 1'b0;
        data_out = (i < 8) ? tx[7 - i] : !ack;
        #160;
        clk_out = 1'b1;
        #160;
      end
      clk_out = 1'b1;
      data_out = 1'b1;
    end
  endtask : frame
endmodule : serial_peer

/* testbench/testbench.sv */
// Self-checking bench for serial port zero
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [1:0] mode;
    logic ms;
    logic sod;
    logic [9:0] exp;
  } row_s;
  logic clk_in, rst_b_in, halt_in, tw;
  logic [4:0] pv;
  logic [7:0] sdata;
  serial_zero_pkg::ctrl_s ctrl;
  serial_zero_pkg::pin_drive_s dl, cl, tc, so, si;
  logic [7:0] shreg, prx;
  logic [3:0] cnt, c0;
  logic rel, ack, pclk, pdat, scl, sda, tck;
  int n_fail, tests_run, i;
  row_s rows [6];

  assign scl = (cl.oe ? cl.level : 1'b1) & pclk;
  assign sda = (dl.oe ? dl.level : 1'b1) & pdat;
  assign tck = tc.oe ? tc.level : pclk;

  multimode_serial_port_zero #(.HALF_CYC(4)) u_multimode_serial_port_zero (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ctrl_in(ctrl),
    .latch_in(5'h12), .clock_stop_in(pv[4]), .ce_reset_in(pv[3]),
    .halt_in(halt_in), .wait_release_in(pv[2]), .wait_write_in(pv[1]),
    .wait_set_in(1'b0), .shift_load_in(pv[0]), .shift_data_in(sdata),
    .data_line_in(sda), .clock_line_in(scl),
    .three_wire_clock_pin_in(tck), .three_wire_data_in_pin_in(pdat),
    .data_line_out(dl), .clock_line_out(cl),
    .three_wire_clock_pin_out(tc), .three_wire_data_out_pin_out(so),
    .three_wire_data_in_pin_out(si), .serial_shift_register_out(shreg),
    .clock_count_out(cnt), .released_out(rel), .ack_seen_out(ack)
  );

  serial_peer u_serial_peer (
    .sclk_in(tw ? tck : scl), .data_in(tw ? so.level : sda),
    .clk_out(pclk), .data_out(pdat), .rx_out(prx)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [9:0] pins();
    logic [4:0] oe;
    begin
      oe = {dl.oe, cl.oe, tc.oe, so.oe, si.oe};
      return {oe, oe & {dl.level, cl.level, tc.level, so.level, si.level}};
    end
  endfunction : pins

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic pulse(input logic [4:0] p);
    pv = p;
    @(negedge clk_in);
    pv = 5'h00;
    repeat (2) @(negedge clk_in);
  endtask : pulse

  task automatic setup(input logic [1:0] m, input logic ms, input logic tx);
    ctrl = '0;
    ctrl.mode = serial_zero_pkg::comm_mode_e'(m);
    ctrl.master_role_select = ms;
    ctrl.transmit_direction_select = tx;
    @(negedge clk_in);
    pulse(5'h02);
  endtask : setup

  task automatic wait_cnt(input logic [3:0] v);
    int k;
    for (k = 0; k < 400 && cnt !== v; k++)
      @(negedge clk_in);
    if (cnt !== v)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_cnt

  initial
  begin
    rows = '{'{2'h0, 1'b0, 1'b0, 10'h100}, '{2'h1, 1'b1, 1'b1, 10'h210},
      '{2'h2, 1'b1, 1'b1, 10'h0c6}, '{2'h2, 1'b0, 1'b0, 10'h000},
      '{2'h2, 1'b0, 1'b1, 10'h042}, '{2'h0, 1'b1, 1'b0, 10'h100}};
    rst_b_in = 1'b0;
    halt_in = 1'b0;
    tw = 1'b0;
    pv = 5'h00;
    sdata = 8'h00;
    ctrl = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(negedge clk_in);
    check({pins(), cnt}, 14'h0);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    // Wait-state pin table, then clock-stop back to inputs
    for (i = 0; i < 6; i++)
    begin
      setup(rows[i].mode, rows[i].ms, 1'b0);
      ctrl.serial_out_port_direction = rows[i].sod;
      ctrl.data_line_port_direction = rows[i].sod;
      repeat (2) @(negedge clk_in);
      check({pins(), cnt}, {rows[i].exp, 4'h0});
      pulse(5'h10);
      check(pins(), 10'h000);
    end
    // Two-wire slave receive on external clock
    setup(2'h1, 1'b0, 1'b0);
    pulse(5'h04);
    u_serial_peer.frame(8'ha5, 8, 1'b0);
    repeat (4) @(negedge clk_in);
    check({shreg, cnt, pins()}, {8'ha5, 4'h8, 10'h000});
    u_serial_peer.frame(8'h00, 2, 1'b0);
    repeat (4) @(negedge clk_in);
    check(cnt, 4'h1);
    pulse(5'h08);
    check(cnt, 4'h0);
    pulse(5'h10);
    check({shreg, pins()}, {8'h94, 10'h000});
    // I2C slave transmit, ack on the ninth clock
    setup(2'h0, 1'b0, 1'b1);
    sdata = 8'h3c;
    pulse(5'h01);
    // Release while the master already holds the clock low
    fork
      u_serial_peer.frame(8'hff, 9, 1'b1);
      pulse(5'h04);
    join
    repeat (4) @(negedge clk_in);
    check({prx, ack}, {8'h78, 1'b1});
    pulse(5'h10);
    // I2C slave receive, ack driven from the ninth fall
    setup(2'h0, 1'b0, 1'b0);
    fork
      u_serial_peer.frame(8'h5a, 9, 1'b0);
      pulse(5'h04);
    join
    repeat (4) @(negedge clk_in);
    check({prx, shreg, cnt}, {8'hb4, 8'hb4, 4'h9});
    pulse(5'h10);
    // Three-wire master transmit on internal clock, then halt
    tw = 1'b1;
    setup(2'h2, 1'b1, 1'b1);
    sdata = 8'h96;
    pulse(5'h01);
    pulse(5'h04);
    wait_cnt(4'h8);
    check({prx, tc.oe}, {8'h96, 1'b1});
    halt_in = 1'b1;
    repeat (10) @(negedge clk_in);
    c0 = cnt;
    repeat (20) @(negedge clk_in);
    check(cnt, c0);
    halt_in = 1'b0;
    pulse(5'h10);
    report_and_stop();
  end
endmodule : testbench
